// ===== rtl/aicav_top.sv
// Interrupt, digital comparator and hardware averaging control with an APB slave
`timescale 1ns/10ps
module aicav_top
    import aicav_pkg::*;
(
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          clk_en,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // Conversion input and sequencer events
    input  wire aicav_sample_t conv_in,
    input  wire logic [3:0]    seq_done,
    input  wire logic [3:0]    seq_dma,
    // Results and outputs
    output aicav_result_t      result_out,
    output logic [7:0]         cmp_trigger,
    output logic               irq
);

    logic [11:0]       raw_ff, nxt_raw;
    logic [11:0]       en_ff, nxt_en;
    logic [7:0]        cmp_stat_ff, nxt_cmp_stat;
    logic [2:0]        avg_ff, nxt_avg;
    logic [7:0][7:0]   cmp_ctl_ff, nxt_cmp_ctl;
    logic [7:0][11:0]  thr_lo_ff, nxt_thr_lo;
    logic [7:0][11:0]  thr_hi_ff, nxt_thr_hi;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [7:0]        cmp_ev;
    logic [7:0]        trg_ev;
    logic [7:0]        rst_trg;
    logic [7:0]        rst_irq;
    logic              wr_acc;
    logic              rd_acc;
    logic [11:0]       masked;

    assign wr_acc  = psel && penable && pwrite && clk_en;
    assign rd_acc  = psel && !penable && !pwrite && clk_en;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = rdata_ff;
    assign masked  = raw_ff & en_ff;
    assign irq     = |masked;

    // Comparator reset strobes act in the write cycle only
    always_comb
    begin
        rst_trg = '0;
        rst_irq = '0;
        if (wr_acc && paddr == OFF_CMP_RST)
        begin
            rst_trg = pwdata[POS_RST_TRG +: 8];
            rst_irq = pwdata[POS_RST_IRQ +: 8];
        end
    end

    // Register next-state
    always_comb
    begin
        logic [11:0] ev;
        logic [11:0] clr;
        ev           = '0;
        clr          = '0;
        nxt_en       = en_ff;
        nxt_avg      = avg_ff;
        nxt_cmp_ctl  = cmp_ctl_ff;
        nxt_thr_lo   = thr_lo_ff;
        nxt_thr_hi   = thr_hi_ff;
        nxt_cmp_stat = cmp_stat_ff;
        nxt_rdata    = rdata_ff;
        // Comparator source bit per sequencer is set by any comparator interrupt event on it
        for (int s = 0; s < NUM_SEQ; s++)
        begin
            ev[POS_DONE + s] = seq_done[s];
            ev[POS_DMA + s]  = seq_dma[s];
            ev[POS_CMP + s]  = |cmp_ev && conv_in.seq == 2'(s);
        end
        if (wr_acc)
        begin
            case (paddr)
                OFF_EN:
                begin
                    nxt_en = pwdata[11:0];
                    // Newly enabled completion sources drop stale status
                    clr[3:0] = pwdata[3:0] & ~en_ff[3:0];
                end
                OFF_CLR:      clr = pwdata[11:0];
                OFF_AVG:
                    if (pwdata[2:0] <= AVG_MAX)
                        nxt_avg = pwdata[2:0];
                default:
                begin
                    for (int c = 0; c < NUM_CMP; c++)
                    begin
                        if (paddr == OFF_CMP_BASE + 12'(4 * c))
                            nxt_cmp_ctl[c] = pwdata[7:0];
                        if (paddr == OFF_THR_BASE + 12'(4 * c))
                        begin
                            nxt_thr_lo[c] = pwdata[11:0];
                            nxt_thr_hi[c] = pwdata[27:16];
                        end
                    end
                end
            endcase
        end
        // Set wins over clear
        nxt_raw = (raw_ff & ~clr) | ev;
        if (wr_acc && paddr == OFF_CMP_STAT)
            nxt_cmp_stat = cmp_stat_ff & ~pwdata[7:0];
        nxt_cmp_stat = nxt_cmp_stat | cmp_ev;
        if (rd_acc)
        begin
            nxt_rdata = '0;
            case (paddr)
                OFF_RAW:      nxt_rdata[11:0] = raw_ff;
                OFF_EN:       nxt_rdata[11:0] = en_ff;
                OFF_MASKED:   nxt_rdata[11:0] = masked;
                OFF_CMP_STAT: nxt_rdata[7:0]  = cmp_stat_ff;
                OFF_AVG:      nxt_rdata[2:0]  = avg_ff;
                default:
                begin
                    for (int c = 0; c < NUM_CMP; c++)
                    begin
                        if (paddr == OFF_CMP_BASE + 12'(4 * c))
                            nxt_rdata[7:0] = cmp_ctl_ff[c];
                        if (paddr == OFF_THR_BASE + 12'(4 * c))
                            nxt_rdata = {4'h0, thr_hi_ff[c], 4'h0, thr_lo_ff[c]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            raw_ff      <= '0;
            en_ff       <= '0;
            cmp_stat_ff <= '0;
            avg_ff      <= '0;
            cmp_ctl_ff  <= '0;
            thr_lo_ff   <= {NUM_CMP{THR_LOW_RST}};
            thr_hi_ff   <= {NUM_CMP{THR_HIGH_RST}};
            rdata_ff    <= '0;
        end
        else if (clk_en)
        begin
            raw_ff      <= nxt_raw;
            en_ff       <= nxt_en;
            cmp_stat_ff <= nxt_cmp_stat;
            avg_ff      <= nxt_avg;
            cmp_ctl_ff  <= nxt_cmp_ctl;
            thr_lo_ff   <= nxt_thr_lo;
            thr_hi_ff   <= nxt_thr_hi;
            rdata_ff    <= nxt_rdata;
        end
    end

    // Digital comparators; they see each result as delivered after averaging
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CMP; gc++)
        begin : g_cmp
            aicav_band_t band;
            logic [1:0]  prev_i_ff, nxt_prev_i;
            logic [1:0]  prev_t_ff, nxt_prev_t;
            logic        arm_i_ff, nxt_arm_i;
            logic        arm_t_ff, nxt_arm_t;
            logic        hit;
            logic        hit_i, hit_t;

            assign hit = result_out.valid && conv_in.cmp_en && conv_in.cmp == 3'(gc);

            always_comb
            begin
                if (result_out.data <= thr_lo_ff[gc])
                    band = AICAV_BAND_LOW;
                else if (result_out.data <= thr_hi_ff[gc])
                    band = AICAV_BAND_MID;
                else
                    band = AICAV_BAND_HIGH;
            end

            aicav_judge u_irq (
                .band     (band),
                .prev     (prev_i_ff),
                .armed    (arm_i_ff),
                .ctl      (cmp_ctl_ff[gc][POS_IRQ_MODE +: 4]),
                .hit      (hit_i),
                .nxt_arm  (nxt_arm_i)
            );
            aicav_judge u_trg (
                .band     (band),
                .prev     (prev_t_ff),
                .armed    (arm_t_ff),
                .ctl      (cmp_ctl_ff[gc][POS_TRG_MODE +: 4]),
                .hit      (hit_t),
                .nxt_arm  (nxt_arm_t)
            );

            always_comb
            begin
                nxt_prev_i = prev_i_ff;
                nxt_prev_t = prev_t_ff;
                if (hit)
                begin
                    nxt_prev_i = band;
                    nxt_prev_t = band;
                end
                if (rst_irq[gc])
                    nxt_prev_i = AICAV_BAND_NONE;
                if (rst_trg[gc])
                    nxt_prev_t = AICAV_BAND_NONE;
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    prev_i_ff <= AICAV_BAND_NONE;
                    prev_t_ff <= AICAV_BAND_NONE;
                    arm_i_ff  <= 1'b0;
                    arm_t_ff  <= 1'b0;
                end
                else if (clk_en)
                begin
                    prev_i_ff <= nxt_prev_i;
                    prev_t_ff <= nxt_prev_t;
                    arm_i_ff  <= rst_irq[gc] ? 1'b0 : (hit ? nxt_arm_i : arm_i_ff);
                    arm_t_ff  <= rst_trg[gc] ? 1'b0 : (hit ? nxt_arm_t : arm_t_ff);
                end
            end

            assign cmp_ev[gc]      = hit && hit_i;
            assign trg_ev[gc]      = hit && hit_t;
            assign cmp_trigger[gc] = trg_ev[gc];
        end
    endgenerate

    // Hardware averager: one accumulator per sequencer
    logic [3:0][17:0]  acc_ff, nxt_acc;
    logic [3:0][6:0]   cnt_ff, nxt_cnt;
    aicav_result_t     res_ff, nxt_res;
    logic [6:0]        factor;

    assign factor     = 7'(1) << avg_ff;
    assign result_out = res_ff;

    always_comb
    begin
        logic [17:0] sum;
        sum     = '0;
        nxt_acc = acc_ff;
        nxt_cnt = cnt_ff;
        nxt_res = '0;
        if (conv_in.valid)
        begin
            sum = acc_ff[conv_in.seq] + 18'(conv_in.data);
            if (avg_ff == 3'h0)
            begin
                nxt_res = '{valid: 1'b1, seq: conv_in.seq, data: conv_in.data};
            end
            else if (cnt_ff[conv_in.seq] == factor - 7'(1))
            begin
                // Only a full set of samples leaves the averager
                nxt_res = '{valid: 1'b1, seq: conv_in.seq, data: 12'(sum >> avg_ff)};
                nxt_acc[conv_in.seq] = '0;
                nxt_cnt[conv_in.seq] = '0;
            end
            else
            begin
                nxt_acc[conv_in.seq] = sum;
                nxt_cnt[conv_in.seq] = cnt_ff[conv_in.seq] + 7'(1);
            end
        end
        // A factor change drops partial sums so no mixed average escapes
        if (wr_acc && paddr == OFF_AVG)
        begin
            nxt_acc = '0;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_ff <= '0;
            cnt_ff <= '0;
            res_ff <= '0;
        end
        else if (clk_en)
        begin
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            res_ff <= nxt_res;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    irq_held_a: assert property (irq && !wr_acc |=> irq)
        else $error("irq dropped without a clear");
    irq_quiet_a: assert property (!irq && seq_done == 4'h0 && seq_dma == 4'h0
        && cmp_ev == 8'h0 && !(wr_acc && paddr == OFF_EN) |=> !irq)
        else $error("irq raised without an event");
    clr_drops_a: assert property (wr_acc && paddr == OFF_CLR && pwdata[0]
        && !seq_done[0] |=> !raw_ff[0])
        else $error("done status not cleared");
    enable_clears_a: assert property (wr_acc && paddr == OFF_EN && pwdata[1]
        && !en_ff[1] && !seq_done[1] |=> en_ff[1] && !raw_ff[1])
        else $error("enable did not clear stale status");
    set_wins_a: assert property (clk_en && seq_dma[2] |=> raw_ff[6])
        else $error("dma event lost");
    cmp_set_a: assert property (clk_en && |cmp_ev
        |=> (cmp_stat_ff & $past(cmp_ev)) == $past(cmp_ev))
        else $error("comparator status not set");
    no_avg_a: assert property (clk_en && avg_ff == 3'h0 && conv_in.valid
        |=> res_ff.valid && res_ff.data == $past(conv_in.data))
        else $error("unaveraged result missing");
    partial_held_a: assert property (clk_en && avg_ff != 3'h0 && conv_in.valid
        && cnt_ff[conv_in.seq] != factor - 7'(1) |=> !res_ff.valid)
        else $error("partial average delivered");
    avg_range_a: assert property (avg_ff <= AVG_MAX)
        else $error("averaging factor out of range");
    low_band_a: assert property (res_ff.valid && res_ff.data <= thr_lo_ff[0]
        |-> g_cmp[0].band == AICAV_BAND_LOW)
        else $error("low band misclassified");
    rst_hist_a: assert property (clk_en && rst_irq[0]
        |=> g_cmp[0].prev_i_ff == AICAV_BAND_NONE)
        else $error("history not reset");

    avg_done_c: cover property (res_ff.valid && avg_ff == 3'h2);
    irq_seen_c: cover property (irq ##1 !irq);
    cmp_irq_c:  cover property (|cmp_ev);
    trig_c:     cover property (|trg_ev);

endmodule

// Band mode judge: returns whether this sample fires and the new hysteresis arm
module aicav_judge
    import aicav_pkg::*;
(
    input  wire aicav_band_t band,
    input  wire logic [1:0]  prev,
    input  wire logic        armed,
    input  wire logic [3:0]  ctl,
    output logic             hit,
    output logic             nxt_arm
);
    aicav_mode_t mode;
    logic [1:0]  sel;
    logic        in_band;
    logic        entry;
    logic        opposite;

    assign mode     = aicav_mode_t'(ctl[1:0]);
    assign sel      = ctl[3:2];
    assign in_band  = band == aicav_band_t'(sel);
    assign entry    = in_band && prev != sel;
    // Band code 3 selects no band, which disables the judge
    assign opposite = (sel == 2'(AICAV_BAND_LOW) && band == AICAV_BAND_HIGH)
                   || (sel == 2'(AICAV_BAND_HIGH) && band == AICAV_BAND_LOW);

    always_comb
    begin
        hit     = 1'b0;
        nxt_arm = armed || opposite;
        case (mode)
            AICAV_MODE_ALWAYS:  hit = in_band;
            AICAV_MODE_ONCE:    hit = entry;
            AICAV_MODE_HALWAYS: hit = in_band && armed;
            AICAV_MODE_HONCE:   hit = entry && armed;
            default:            hit = 1'b0;
        endcase
        if (hit && (mode == AICAV_MODE_HALWAYS || mode == AICAV_MODE_HONCE))
            nxt_arm = 1'b0;
    end
endmodule

// ===== shared/aicav_pkg.sv
// Shared constants and types for the converter interrupt, compare and averaging block
package aicav_pkg;

    localparam int          DATA_W        = 12;
    localparam int          NUM_SEQ       = 4;
    localparam int          NUM_CMP       = 8;
    localparam int          NUM_SRC       = 12;

    // Register byte offsets
    localparam logic [11:0] OFF_RAW       = 12'h000;
    localparam logic [11:0] OFF_EN        = 12'h004;
    localparam logic [11:0] OFF_MASKED    = 12'h008;
    localparam logic [11:0] OFF_CLR       = 12'h00C;
    localparam logic [11:0] OFF_CMP_STAT  = 12'h010;
    localparam logic [11:0] OFF_AVG       = 12'h014;
    localparam logic [11:0] OFF_CMP_RST   = 12'h018;
    localparam logic [11:0] OFF_CMP_BASE  = 12'h040;
    localparam logic [11:0] OFF_THR_BASE  = 12'h060;

    // Source bit groups inside the 12-bit raw/enable/masked words
    localparam int          POS_DONE      = 0;
    localparam int          POS_DMA       = 4;
    localparam int          POS_CMP       = 8;

    // Comparator control word fields
    localparam int          POS_IRQ_MODE  = 0;
    localparam int          POS_IRQ_BAND  = 2;
    localparam int          POS_TRG_MODE  = 4;
    localparam int          POS_TRG_BAND  = 6;

    // Comparator history reset word fields
    localparam int          POS_RST_TRG   = 0;
    localparam int          POS_RST_IRQ   = 16;

    localparam logic [2:0]  AVG_MAX       = 3'h6;
    localparam logic [11:0] THR_LOW_RST   = 12'h000;
    localparam logic [11:0] THR_HIGH_RST  = 12'hFFF;

    typedef enum logic [1:0] {
        AICAV_BAND_LOW  = 2'b00,
        AICAV_BAND_MID  = 2'b01,
        AICAV_BAND_HIGH = 2'b10,
        AICAV_BAND_NONE = 2'b11
    } aicav_band_t;

    typedef enum logic [1:0] {
        AICAV_MODE_ALWAYS  = 2'b00,
        AICAV_MODE_ONCE    = 2'b01,
        AICAV_MODE_HALWAYS = 2'b10,
        AICAV_MODE_HONCE   = 2'b11
    } aicav_mode_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  seq;
        logic [2:0]  cmp;
        logic        cmp_en;
        logic [11:0] data;
    } aicav_sample_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  seq;
        logic [11:0] data;
    } aicav_result_t;

endpackage

// ===== testbench/aicav_tb_top.sv
// Self-checking bench for the interrupt, compare and averaging block
`timescale 1ns/10ps
module aicav_tb_top
    import aicav_pkg::*;
;
    logic          pclk, presetn, clk_en, psel, penable, pwrite;
    logic          pready, pslverr, irq, err;
    logic [11:0]   paddr, res_data, lo, hi, v, e, raw, ca, ta;
    logic [31:0]   pwdata, prdata, rd;
    logic [3:0]    seq_done, seq_dma;
    logic [7:0]    cmp_trigger, trg_acc;
    logic [1:0]    res_seq;
    aicav_sample_t conv_in;
    aicav_result_t result_out;
    int            bad_count, num_checks, res_cnt, seed;

    aicav_top u_dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .clk_en      (clk_en),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .conv_in     (conv_in),
        .seq_done    (seq_done),
        .seq_dma     (seq_dma),
        .result_out  (result_out),
        .cmp_trigger (cmp_trigger),
        .irq         (irq)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Results are counted here so that no result slips past a busy main sequence
    always @(posedge pclk)
    begin
        if (result_out.valid === 1'b1)
        begin
            res_cnt <= res_cnt + 1;
            res_data <= result_out.data;
            res_seq <= result_out.seq;
            trg_acc <= trg_acc | cmp_trigger;
        end
    end

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Called just after a rising edge; returns just after one
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n == 20)
            bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Routing fields are held one more cycle, where the comparator looks at them
    task automatic conv(input logic [1:0] s, input logic [2:0] c, input logic en,
                        input logic [11:0] d);
        conv_in <= '{1'b1, s, c, en, d};
        @(posedge pclk);
        conv_in.valid <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse(input logic [3:0] dn, input logic [3:0] dm);
        seq_done <= dn;
        seq_dma <= dm;
        @(posedge pclk);
        seq_done <= 4'h0;
        seq_dma <= 4'h0;
        @(posedge pclk);
    endtask

    function automatic logic [1:0] band_of(input logic [11:0] d);
        if (d <= lo)
            return 2'h0;
        if (d <= hi)
            return 2'h1;
        return 2'h2;
    endfunction

    initial
    begin
        logic [3:0]  dn, dm;
        logic [1:0]  s;
        logic [2:0]  c;
        logic [11:0] vals [5];
        logic        hit;
        seed = 32'h45DE;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {seq_done, seq_dma, conv_in, bad_count, num_checks, res_cnt} = '0;
        trg_acc = 8'h00;
        clk_en = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(OFF_RAW, 32'h0);
        rdchk(OFF_EN, 32'h0);
        rdchk(OFF_MASKED, 32'h0);
        rdchk(OFF_CMP_STAT, 32'h0);
        rdchk(OFF_AVG, 32'h0);
        rdchk(OFF_THR_BASE, {4'h0, THR_HIGH_RST, 4'h0, THR_LOW_RST});
        rdchk(12'h030, 32'h0);
        check({31'h0, err}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            dn = (i == 0) ? 4'hF : 4'($random(seed));
            dm = (i == 0) ? 4'hF : 4'($random(seed));
            pulse(dn, dm);
            raw = {4'h0, dm, dn};
            rdchk(OFF_RAW, {20'h0, raw});
            check({31'h0, irq}, 32'h0);
            e = (i == 0) ? 12'hFFF : 12'($random(seed));
            wr(OFF_EN, {20'h0, e});
            // Enabling a completion source drops what was pending on it
            raw = raw & ~{8'h0, e[3:0]};
            rdchk(OFF_RAW, {20'h0, raw});
            rdchk(OFF_MASKED, {20'h0, raw & e});
            check({31'h0, irq}, {31'h0, |(raw & e)});
            pulse(4'hF, 4'h0);
            raw[3:0] = 4'hF;
            wr(OFF_CLR, {20'h0, raw & ~e});
            check({31'h0, irq}, {31'h0, |(raw & e)});
            wr(OFF_CLR, 32'hFFF);
            check({31'h0, irq}, 32'h0);
            rdchk(OFF_RAW, 32'h0);
            wr(OFF_EN, 32'h0);
        end
        // A low clock enable must swallow events entirely
        clk_en <= 1'b0;
        pulse(4'h5, 4'hA);
        clk_en <= 1'b1;
        rdchk(OFF_RAW, 32'h0);
        // Symmetric pairs give an exact mean, so truncation choices cannot matter
        for (int k = 1; k <= 6; k++)
        begin
            wr(OFF_AVG, k);
            s = 2'($random(seed));
            v = 12'h040 + (12'($random(seed)) & 12'h7FF);
            e = 12'($random(seed)) & 12'h03F;
            res_cnt = 0;
            for (int j = 0; j < (1 << k); j++)
                conv(s, 3'h0, 1'b0, j[0] ? v - e : v + e);
            @(posedge pclk);
            check(res_cnt, 32'h1);
            check({20'h0, res_data}, {20'h0, v});
            check({30'h0, res_seq}, {30'h0, s});
        end
        wr(OFF_AVG, 32'h7);
        rdchk(OFF_AVG, 32'h6);
        wr(OFF_AVG, 32'h0);
        res_cnt = 0;
        for (int j = 0; j < 4; j++)
        begin
            v = 12'($random(seed));
            conv(2'(j), 3'h0, 1'b0, v);
            @(posedge pclk);
            check({20'h0, res_data}, {20'h0, v});
            check({30'h0, res_seq}, j);
        end
        check(res_cnt, 32'h4);
        c = 3'($random(seed));
        ca = OFF_CMP_BASE + {7'h0, c, 2'b00};
        ta = OFF_THR_BASE + {7'h0, c, 2'b00};
        lo = 12'h100 + (12'($random(seed)) & 12'h3FF);
        hi = lo + 12'h010 + (12'($random(seed)) & 12'h3FF);
        wr(ta, {4'h0, hi, 4'h0, lo});
        rdchk(ta, {4'h0, hi, 4'h0, lo});
        vals = '{lo, lo + 12'h1, hi, hi + 12'h1, 12'h000};
        for (int b = 0; b < 3; b++)
        begin
            wr(ca, {24'h0, 2'(b), 2'h0, 2'(b), 2'h0});
            foreach (vals[t])
            begin
                s = 2'($random(seed));
                trg_acc = 8'h00;
                conv(s, c, 1'b1, vals[t]);
                hit = (band_of(vals[t]) == 2'(b));
                rdchk(OFF_CMP_STAT, {24'h0, 8'(hit) << c});
                rdchk(OFF_RAW, {20'h0, 4'(hit) << s, 8'h0});
                check({24'h0, trg_acc}, {24'h0, 8'(hit) << c});
                wr(OFF_CMP_STAT, 32'hFF);
                wr(OFF_CLR, 32'hFFF);
            end
        end
        conv(2'h1, c, 1'b1, hi + 12'h1);
        wr(OFF_CMP_STAT, {24'h0, ~(8'h1 << c)});
        rdchk(OFF_CMP_STAT, {24'h0, 8'h1 << c});
        wr(OFF_CMP_STAT, {24'h0, 8'h1 << c});
        rdchk(OFF_CMP_STAT, 32'h0);
        // Interrupt once on entry to the mid band
        wr(ca, 32'hC5);
        conv(2'h2, c, 1'b1, lo + 12'h1);
        rdchk(OFF_CMP_STAT, {24'h0, 8'h1 << c});
        wr(OFF_CMP_STAT, 32'hFF);
        conv(2'h2, c, 1'b1, hi);
        rdchk(OFF_CMP_STAT, 32'h0);
        wr(OFF_CMP_RST, {24'h0, 8'h1 << c});
        conv(2'h2, c, 1'b1, hi);
        rdchk(OFF_CMP_STAT, 32'h0);
        wr(OFF_CMP_RST, {8'h0, 8'hFF, 16'h0});
        conv(2'h2, c, 1'b1, hi);
        rdchk(OFF_CMP_STAT, {24'h0, 8'h1 << c});
        wr(OFF_CMP_STAT, 32'hFF);
        // Hysteresis on the low band needs a visit to the high band first
        wr(ca, 32'hC2);
        conv(2'h3, c, 1'b1, hi + 12'h1);
        conv(2'h3, c, 1'b1, lo);
        rdchk(OFF_CMP_STAT, {24'h0, 8'h1 << c});
        wr(OFF_CMP_STAT, 32'hFF);
        conv(2'h3, c, 1'b1, lo);
        rdchk(OFF_CMP_STAT, 32'h0);
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        test_done();
    end
endmodule
